// ===== design/rcf_pkg.sv
// Package for the reset cause flags block: register map, bit positions, reset values, carriers
package rcf_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the AXI4-Lite bus
  // ----------------------------------------------------------------
  localparam logic [3:0] RCF_OFS_STATUS   = 4'h0;  // Reset cause status flags
  localparam logic [3:0] RCF_OFS_IRQ_STAT = 4'h4;  // Sticky event bits, cleared by reading
  localparam logic [3:0] RCF_OFS_IRQ_MASK = 4'h8;  // Interrupt enables, same layout
  localparam logic [3:0] RCF_OFS_CONTROL  = 4'hC;  // Watchdog software enable

  // ----------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------
  localparam int RCF_BIT_TRAP    = 15;  // Trap conflict
  localparam int RCF_BIT_OPCODE  = 14;  // Illegal opcode or bad working register access
  localparam int RCF_BIT_CONFIG  = 9;   // Configuration mismatch
  localparam int RCF_BIT_PIN     = 7;   // Master clear pin reset
  localparam int RCF_BIT_SOFT    = 6;   // Reset instruction
  localparam int RCF_BIT_WDOG    = 4;   // Watchdog expiry
  localparam int RCF_BIT_SLEEP   = 3;   // Woke from sleep
  localparam int RCF_BIT_IDLE    = 2;   // Woke from idle
  localparam int RCF_BIT_SUPPLY  = 1;   // Brown-out
  localparam int RCF_BIT_POWERON = 0;   // Power-on
  localparam int RCF_BIT_SOFT_WATCHDOG_ENABLE  = 0;   // Control: software watchdog enable

  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RCF_IMPL_MASK  = 16'hC2DF;  // Implemented status bits
  localparam logic [15:0] RCF_POR_CLEAR  = 16'hC2DC;  // Flags cleared by power-on
  localparam logic [15:0] RCF_POR_SET    = 16'h0003;  // Flags set by power-on
  localparam logic [15:0] RCF_STATUS_RST = 16'h0003;  // Status after bus reset
  localparam logic [15:0] RCF_IRQ_RST    = 16'h0000;  // Interrupt status after reset
  localparam logic [15:0] RCF_MASK_RST   = 16'h0000;  // Interrupt mask after reset
  localparam logic        RCF_SOFT_WATCHDOG_ENABLE_RST = 1'b0;      // Software watchdog enable after reset
  localparam logic [1:0]  RCF_FUSE_UNPROG = 2'h3;     // Unprogrammed watchdog fuse field

  // ----------------------------------------------------------------
  // AXI response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RCF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RCF_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Event carrier: one-cycle pulses from core logic on aclk
  // ----------------------------------------------------------------
  typedef struct packed {
    logic trap_conflict;     // Trap conflict detected
    logic bad_opcode;        // Illegal opcode or uninitialised register access
    logic config_mismatch;   // Configuration mismatch reset
    logic soft_reset_instr;  // Reset instruction executed
    logic watchdog_expiry;   // Watchdog counter expired
    logic power_save_instr;  // Power-save instruction executed
    logic power_save_idle;   // Selects idle (1) or sleep (0) with the above
    logic supply_dip;        // Brown-out reset
    logic power_on;          // Power-on reset
  } rcf_event_type;

endpackage : rcf_pkg

// ===== design/rcf_reset_cause_flags.sv
// Reset cause flags with AXI4-Lite register access and a masked interrupt
//
// What this block does
// RULE_01: Watchdog flag set on expiry, cleared by power-save/power-on
// RULE_02: Sleep flag set by sleep instruction, power-on clears
// RULE_03: Idle flag set by idle instruction, power-on clears
// RULE_04: Brown-out flag set by brown-out or power-on
// RULE_05: Power-on flag set by power-on, software clears
// RULE_06: Trap, opcode, mismatch, pin, instruction flags; power-on clears
// RULE_07: Software sets or clears flags without causing reset
// RULE_08: Unprogrammed fuse keeps watchdog on regardless
// RULE_09: Flags hold until own clear; several coexist
`timescale 1ns/1ps

module rcf_reset_cause_flags #(
  parameter int AXI_ADDR_WIDTH = 4  // Byte address width of the register window
) (
  input  wire logic                      aclk,                 // System clock, 250 MHz
  input  wire logic                      aresetn,              // Synchronous reset, active low
  // AXI4-Lite write address channel
  input  wire logic                      s_axi_awvalid,
  output      logic                      s_axi_awready,
  input  wire logic [AXI_ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  // AXI4-Lite write data channel
  input  wire logic                      s_axi_wvalid,
  output      logic                      s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  // AXI4-Lite write response channel
  output      logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output      logic [1:0]                s_axi_bresp,
  // AXI4-Lite read address channel
  input  wire logic                      s_axi_arvalid,
  output      logic                      s_axi_arready,
  input  wire logic [AXI_ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  // AXI4-Lite read data channel
  output      logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output      logic [31:0]               s_axi_rdata,
  output      logic [1:0]                s_axi_rresp,
  // Reset and power events from core logic
  input  wire rcf_pkg::rcf_event_type    events,
  input  wire logic                      master_clear_pin_n,   // External reset pin, asynchronous
  input  wire logic [1:0]                watchdog_fuse_enable, // Watchdog enable fuse field
  // Results
  output      logic                      watchdog_enabled,     // Watchdog runs
  output      logic [15:0]               reset_cause_flags,    // Copy of the status flags
  output      logic                      irq                   // Level interrupt
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (AXI_ADDR_WIDTH < 4) begin : g_addr_check
    $error("AXI_ADDR_WIDTH must be at least 4 to reach every register");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0]               reset_cause_status;    // Stored flags
  logic [15:0]               next_reset_cause_status;
  logic [15:0]               irq_status;            // Sticky event bits
  logic [15:0]               next_irq_status;
  logic [15:0]               irq_mask;              // Interrupt enables
  logic                      soft_watchdog_enable;  // Control bit
  logic                      pin_sync_a;            // Pin synchroniser, first stage
  logic                      pin_sync_b;            // Pin synchroniser, second stage
  logic                      pin_prev;              // Previous synchronised pin level
  logic                      pin_reset_edge;        // Pin went low this cycle
  logic [15:0]               set_vec;               // Flags raised by hardware this cycle
  logic [AXI_ADDR_WIDTH-1:0] wr_addr;               // Captured write address
  logic                      wr_addr_held;          // Write address captured
  logic [31:0]               wr_data;               // Captured write data
  logic [3:0]                wr_strb;               // Captured byte strobes
  logic                      wr_data_held;          // Write data captured
  logic                      wr_fire;               // Write is performed this cycle
  logic [15:0]               wr_lanes;              // Bit enables from the strobes
  logic                      rd_fire;               // Read address taken this cycle
  logic [31:0]               rd_value;              // Read data for the taken address
  logic                      rd_ok;                 // Read address is mapped
  logic                      wr_ok;                 // Write address is mapped
  logic                      sel_status;            // Write targets status register
  logic                      sel_mask;              // Write targets mask register
  logic                      sel_control;           // Write targets control register
  logic                      rd_irq_clear;          // Read of interrupt status

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------

  // Two flops bring the asynchronous pin onto aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync_a <= 1'b1;
      pin_sync_b <= 1'b1;
      pin_prev   <= 1'b1;
    end else begin
      pin_sync_a <= master_clear_pin_n;
      pin_sync_b <= pin_sync_a;
      pin_prev   <= pin_sync_b;
    end
  end

  // A falling level on the synchronised pin is one reset event
  assign pin_reset_edge = pin_prev & ~pin_sync_b;

  // ----------------------------------------------------------------
  // Hardware set events
  // ----------------------------------------------------------------

  // One bit per flag, so several causes can rise together
  always_comb begin
    set_vec                 = 16'h0000;  // [RULE_09]
    set_vec[rcf_pkg::RCF_BIT_TRAP]    = events.trap_conflict;  // [RULE_06]
    set_vec[rcf_pkg::RCF_BIT_OPCODE]  = events.bad_opcode;  // [RULE_06]
    set_vec[rcf_pkg::RCF_BIT_CONFIG]  = events.config_mismatch;  // [RULE_06]
    set_vec[rcf_pkg::RCF_BIT_PIN]     = pin_reset_edge;  // [RULE_06]
    set_vec[rcf_pkg::RCF_BIT_SOFT]    = events.soft_reset_instr;  // [RULE_06]
    // Only a running watchdog can expire
    set_vec[rcf_pkg::RCF_BIT_WDOG]    = events.watchdog_expiry & watchdog_enabled;  // [RULE_01]
    set_vec[rcf_pkg::RCF_BIT_SLEEP]   = events.power_save_instr & ~events.power_save_idle;  // [RULE_02]
    set_vec[rcf_pkg::RCF_BIT_IDLE]    = events.power_save_instr & events.power_save_idle;  // [RULE_03]
    set_vec[rcf_pkg::RCF_BIT_SUPPLY]  = events.supply_dip | events.power_on;  // [RULE_04]
    set_vec[rcf_pkg::RCF_BIT_POWERON] = events.power_on;  // [RULE_05]
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------

  // Write happens once both halves are captured and no response is pending
  assign wr_fire = wr_addr_held & wr_data_held & ~s_axi_bvalid;

  // Strobes 0 and 1 cover the 16 register bits
  assign wr_lanes = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // Address decode for writes
  always_comb begin
    sel_status  = 1'b0;
    sel_mask    = 1'b0;
    sel_control = 1'b0;
    wr_ok       = 1'b1;
    if (wr_addr[3:0] == rcf_pkg::RCF_OFS_STATUS) begin
      sel_status = 1'b1;
    end else if (wr_addr[3:0] == rcf_pkg::RCF_OFS_IRQ_MASK) begin
      sel_mask = 1'b1;
    end else if (wr_addr[3:0] == rcf_pkg::RCF_OFS_CONTROL) begin
      sel_control = 1'b1;
    end else if (wr_addr[3:0] == rcf_pkg::RCF_OFS_IRQ_STAT) begin
      wr_ok = 1'b1;  // Read-clear register: writes ignored
    end else begin
      wr_ok = 1'b0;  // Unmapped
    end
    if ((wr_addr >> 4) != '0) begin
      sel_status  = 1'b0;
      sel_mask    = 1'b0;
      sel_control = 1'b0;
      wr_ok       = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status flag update
  // ----------------------------------------------------------------

  // Software first, then hardware clears, then hardware sets so sets always win
  always_comb begin
    next_reset_cause_status = reset_cause_status;
    // Software may write any flag; storing a one starts no reset
    if (wr_fire && sel_status) begin
      next_reset_cause_status = (reset_cause_status & ~wr_lanes)
                              | (wr_data[15:0] & wr_lanes);  // [RULE_07]
    end
    // Power-save instruction clears the watchdog flag
    if (events.power_save_instr) begin
      next_reset_cause_status[rcf_pkg::RCF_BIT_WDOG] = 1'b0;  // [RULE_01]
    end
    // Power-on clears the cause flags it owns
    if (events.power_on) begin
      next_reset_cause_status = next_reset_cause_status & ~rcf_pkg::RCF_POR_CLEAR;  // [RULE_02] [RULE_03] [RULE_06]
    end
    next_reset_cause_status = (next_reset_cause_status | set_vec) & rcf_pkg::RCF_IMPL_MASK;  // [RULE_09]
  end

  // Flags register; holds unless an event or write above changes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_cause_status <= rcf_pkg::RCF_STATUS_RST;  // [RULE_04] [RULE_05]
    end else begin
      reset_cause_status <= next_reset_cause_status;  // [RULE_09]
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------

  // Reading clears; an event in the same cycle stays set
  always_comb begin
    next_irq_status = irq_status;
    if (rd_irq_clear) begin
      next_irq_status = 16'h0000;
    end
    next_irq_status = next_irq_status | set_vec;
  end

  // Sticky event register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= rcf_pkg::RCF_IRQ_RST;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Mask register, same layout as the status bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= rcf_pkg::RCF_MASK_RST;
    end else if (wr_fire && sel_mask) begin
      irq_mask <= ((irq_mask & ~wr_lanes) | (wr_data[15:0] & wr_lanes)) & rcf_pkg::RCF_IMPL_MASK;
    end
  end

  // Registered interrupt level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Watchdog enable
  // ----------------------------------------------------------------

  // Software enable bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_watchdog_enable <= rcf_pkg::RCF_SOFT_WATCHDOG_ENABLE_RST;
    end else if (wr_fire && sel_control && wr_strb[0]) begin
      soft_watchdog_enable <= wr_data[rcf_pkg::RCF_BIT_SOFT_WATCHDOG_ENABLE];
    end
  end

  // Unprogrammed fuse forces the watchdog on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_enabled <= 1'b0;
    end else begin
      watchdog_enabled <= (watchdog_fuse_enable == rcf_pkg::RCF_FUSE_UNPROG)
                        | soft_watchdog_enable;  // [RULE_08]
    end
  end

  // Copy of the flags for the rest of the chip
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_cause_flags <= rcf_pkg::RCF_STATUS_RST;
    end else begin
      reset_cause_flags <= next_reset_cause_status;
    end
  end

  // ----------------------------------------------------------------
  // AXI write channels
  // ----------------------------------------------------------------

  // Address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      wr_addr_held  <= 1'b0;
      wr_addr       <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      wr_addr_held  <= 1'b1;
      wr_addr       <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      wr_addr_held  <= 1'b0;
    end else if (!wr_addr_held) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      wr_data_held <= 1'b0;
      wr_data      <= 32'h0000_0000;
      wr_strb      <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wr_data_held <= 1'b1;
      wr_data      <= s_axi_wdata;
      wr_strb      <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      wr_data_held <= 1'b0;
    end else if (!wr_data_held) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response, one cycle after the write is performed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rcf_pkg::RCF_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? rcf_pkg::RCF_RESP_OKAY : rcf_pkg::RCF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI read channels
  // ----------------------------------------------------------------

  assign rd_fire = s_axi_arvalid & s_axi_arready;

  // Read decode
  always_comb begin
    rd_value     = 32'h0000_0000;
    rd_ok        = 1'b1;
    rd_irq_clear = 1'b0;
    if ((s_axi_araddr >> 4) != '0) begin
      rd_ok = 1'b0;
    end else if (s_axi_araddr[3:0] == rcf_pkg::RCF_OFS_STATUS) begin
      rd_value[15:0] = reset_cause_status;
    end else if (s_axi_araddr[3:0] == rcf_pkg::RCF_OFS_IRQ_STAT) begin
      rd_value[15:0] = irq_status;
      rd_irq_clear   = rd_fire;
    end else if (s_axi_araddr[3:0] == rcf_pkg::RCF_OFS_IRQ_MASK) begin
      rd_value[15:0] = irq_mask;
    end else if (s_axi_araddr[3:0] == rcf_pkg::RCF_OFS_CONTROL) begin
      rd_value[rcf_pkg::RCF_BIT_SOFT_WATCHDOG_ENABLE] = soft_watchdog_enable;
      rd_value[1]              = watchdog_enabled;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read address ready, dropped while data waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
    end else if (!s_axi_rvalid || s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Read data, registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= rcf_pkg::RCF_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_ok ? rcf_pkg::RCF_RESP_OKAY : rcf_pkg::RCF_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : rcf_reset_cause_flags

// ===== tb/rcf_checker.sv
// Concurrent checks on the reset cause flags block ports
`timescale 1ns/1ps
module rcf_checker (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire rcf_pkg::rcf_event_type events,
  input wire logic                   master_clear_pin_n,
  input wire logic [1:0]             watchdog_fuse_enable,
  input wire logic                   watchdog_enabled,
  input wire logic [15:0]            reset_cause_flags,
  input wire logic                   s_axi_bvalid
);
  // ----------------------------------------------------------------
  // Clocking and pin history
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] pin_hist;  // Recent pin samples, so a late pin event is excluded
  logic       pin_quiet; // Pin high long enough that no pin event can land
  // Shift the pin level in every cycle
  always_ff @(posedge aclk) begin
    pin_hist <= {pin_hist[2:0], master_clear_pin_n};
  end
  assign pin_quiet = master_clear_pin_n & (&pin_hist);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  trap_set_a: assert property (events.trap_conflict |=> reset_cause_flags[15])
    else $error("trap flag not set");
  opcode_set_a: assert property (events.bad_opcode |=> reset_cause_flags[14])
    else $error("opcode flag not set");
  sleep_set_a: assert property (events.power_save_instr && !events.power_save_idle |=> reset_cause_flags[3])
    else $error("sleep flag not set");
  idle_set_a: assert property (events.power_save_instr && events.power_save_idle |=> reset_cause_flags[2])
    else $error("idle flag not set");
  wdog_clear_a: assert property (events.power_save_instr && !events.watchdog_expiry |=> !reset_cause_flags[4])
    else $error("watchdog flag not cleared");
  wdog_set_a: assert property (events.watchdog_expiry && watchdog_enabled |=> reset_cause_flags[4])
    else $error("watchdog flag not set");
  por_set_a: assert property (events.power_on |=> reset_cause_flags[1:0] == 2'h3)
    else $error("power-on flags not set");
  por_clear_a: assert property (events == 9'h001 && pin_quiet |=> (reset_cause_flags & 16'hC2DC) == 16'h0000)
    else $error("power-on did not clear flags");
  flags_hold_a: assert property (events == 9'h000 && pin_quiet |=> $stable(reset_cause_flags) || $rose(s_axi_bvalid))
    else $error("flags changed without cause");
  fuse_force_a: assert property (watchdog_fuse_enable == 2'h3 ##1 watchdog_fuse_enable == 2'h3 |-> watchdog_enabled)
    else $error("fuse did not force watchdog on");
endmodule : rcf_checker

bind rcf_reset_cause_flags rcf_checker chk_i (.aclk(aclk), .aresetn(aresetn), .events(events),
  .master_clear_pin_n(master_clear_pin_n), .watchdog_fuse_enable(watchdog_fuse_enable),
  .watchdog_enabled(watchdog_enabled), .reset_cause_flags(reset_cause_flags), .s_axi_bvalid(s_axi_bvalid));

// ===== tb/test_reset_cause_flags.sv
// Self-checking bench for the reset cause flags block
`timescale 1ns/1ps
module test_reset_cause_flags;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                   aclk, aresetn, awv, wv, brd, arv, rrd, pin_n;  // Driven inputs
  wire logic              awr, wr_rdy, bv, arr, rv, wd_en, irq;          // Design outputs
  logic [4:0]             awa, ara;                                      // Byte addresses
  logic [31:0]            wda, d;                                        // Write and read data
  wire logic [31:0]       rda;                                           // Read data bus
  wire logic [1:0]        bresp, rresp;                                  // Responses
  logic [1:0]             fuse, r;                                       // Fuse field, last response
  wire logic [15:0]       flags;                                         // Status copy
  rcf_pkg::rcf_event_type ev;                                            // Event pulses
  int                     mismatches = 0, total_checks = 0, cyc = 0;     // Counters
  logic [8:0]  ev_tab [9]  = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h00C, 9'h002, 9'h001};
  logic [15:0] exp_tab [9] = '{16'h8000, 16'h4000, 16'h0200, 16'h0040, 16'h0010, 16'h0008, 16'h0004,
                               16'h0002, 16'h0003};

  rcf_reset_cause_flags #(.AXI_ADDR_WIDTH(5)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wda), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rrd), .s_axi_rdata(rda), .s_axi_rresp(rresp),
    .events(ev), .master_clear_pin_n(pin_n), .watchdog_fuse_enable(fuse),
    .watchdog_enabled(wd_en), .reset_cause_flags(flags), .irq(irq));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Bus write, address and data offered together
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge aclk);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wda <= v; brd <= 1'b1;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (!(bv && brd));
    r = bresp;
    brd <= 1'b0;
  endtask : wr
  // Bus read into d and r
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    arv <= 1'b1; ara <= a; rrd <= 1'b1;
    do begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end while (!(rv && rrd));
    d = rda;
    r = rresp;
    rrd <= 1'b0;
  endtask : rd
  // One-cycle event pulse
  task automatic pulse(input logic [8:0] v);
    @(posedge aclk);
    ev <= rcf_pkg::rcf_event_type'(v);
    @(posedge aclk);
    ev <= '0;
  endtask : pulse
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Cut a hang short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    aresetn = 0; awv = 0; wv = 0; brd = 0; arv = 0; rrd = 0; pin_n = 1;
    awa = '0; ara = '0; wda = '0; fuse = 2'h3; ev = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(5'h00); chk(d, 32'h3);
    rd(5'h08); chk(d, 32'h0);
    rd(5'h0C); chk(d, 32'h2);
    // Table: clear, pulse one event, read back
    for (int i = 0; i < 9; i++) begin
      wr(5'h00, 32'h0);
      pulse(ev_tab[i]);
      rd(5'h00);
      chk(d, {16'h0000, exp_tab[i]});
      chk({16'h0000, flags}, {16'h0000, exp_tab[i]});
    end
    // Software sets all, power-save then power-on
    wr(5'h00, 32'hFFFF); chk({30'h0, r}, 32'h0);
    rd(5'h00); chk(d, 32'hC2DF);
    pulse(9'h008);
    rd(5'h00); chk(d, 32'hC2CF);
    pulse(9'h001);
    rd(5'h00); chk(d, 32'h3);
    // Several causes together, pin reset included
    wr(5'h00, 32'h0);
    pulse(9'h100);
    pulse(9'h020);
    @(posedge aclk) pin_n <= 1'b0;
    repeat (3) @(posedge aclk);
    pin_n <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(5'h00); chk(d, 32'h80C0);
    // Fuse programmed: software enable decides
    fuse <= 2'h0;
    wr(5'h00, 32'h0);
    @(posedge aclk); chk({31'h0, wd_en}, 32'h0);
    pulse(9'h010);
    rd(5'h00); chk(d, 32'h0);
    wr(5'h0C, 32'h1);
    @(posedge aclk); chk({31'h0, wd_en}, 32'h1);
    pulse(9'h010);
    rd(5'h00); chk(d, 32'h10);
    // Interrupt: clear, mask, raise, read-clear
    rd(5'h04);
    wr(5'h08, 32'h8000);
    pulse(9'h080);
    @(posedge aclk); chk({31'h0, irq}, 32'h0);
    pulse(9'h100);
    @(posedge aclk); chk({31'h0, irq}, 32'h1);
    rd(5'h04); chk(d, 32'hC000);
    @(posedge aclk); chk({31'h0, irq}, 32'h0);
    // Unmapped place refused without effect
    rd(5'h10); chk(d, 32'h0);
    chk({30'h0, r}, 32'h2);
    wr(5'h10, 32'hFFFF); chk({30'h0, r}, 32'h2);
    rd(5'h00); chk(d, 32'hC010);
    // Mid-run reset restores power-on flags and clears the mask
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(5'h00); chk(d, 32'h3);
    chk({16'h0000, flags}, 32'h3);
    rd(5'h08); chk(d, 32'h0);
    close_out();
  end
endmodule : test_reset_cause_flags
